// File: verilog/boot_clk_pkg.sv
// Constants and types shared by the boot clock configuration decoder.
package boot_clk_pkg;

  // Register byte addresses.
  localparam logic [15:0] ADDR_CFG_WORD_THREE = 16'h2ff0;
  localparam logic [15:0] ADDR_CFG_WORD_TWO = 16'h2ff4;
  localparam logic [15:0] ADDR_CFG_WORD_ONE = 16'h2ff8;
  localparam logic [15:0] ADDR_CFG_WORD_ZERO = 16'h2ffc;
  localparam logic [15:0] ADDR_CLK_STATUS = 16'h3000;
  localparam logic [15:0] ADDR_CLK_CONTROL = 16'h3004;

  // Field positions inside configuration word one.
  localparam int POS_PERIPH_DIV = 12;
  localparam int POS_RSVD_B11 = 11;
  localparam int POS_CLKOUT_DIS = 10;
  localparam int POS_POSC_MODE = 8;
  localparam int POS_TWO_SPEED = 7;
  localparam int POS_RSVD_B6 = 6;
  localparam int POS_SOSC_EN = 5;
  localparam int POS_RSVD_B3 = 3;
  localparam int POS_OSC_SEL = 0;

  // Status and control bit positions.
  localparam int POS_ST_VALID = 0;
  localparam int POS_ST_RSVD_ERR = 1;
  localparam int POS_ST_CONFLICT = 2;
  localparam int POS_ST_CLKOUT_ON = 3;
  localparam int POS_CTL_SUPPRESS = 0;

  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic RST_SUPPRESS = 1'b0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    POSC_EXT = 2'h0,
    POSC_XT = 2'h1,
    POSC_HS = 2'h2,
    POSC_OFF = 2'h3
  } posc_mode_t;

  typedef enum logic [2:0] {
    SRC_FRC = 3'h0,
    SRC_FAST_RC_DIVIDED_PLL = 3'h1,
    SRC_POSC = 3'h2,
    SRC_POSC_PLL = 3'h3,
    SRC_SOSC = 3'h4,
    SRC_LOW_POWER_RC_OSC = 3'h5,
    SRC_FRC_DIV16 = 3'h6,
    SRC_FAST_RC_DIVIDED = 3'h7
  } osc_sel_t;

  typedef struct packed {
    logic [31:0] word_three;
    logic [31:0] word_two;
    logic [31:0] word_one;
    logic [31:0] word_zero;
  } cfg_words_t;

  typedef struct packed {
    logic [1:0] periph_div;
    logic clkout_dis;
    posc_mode_t posc_mode;
    logic two_speed;
    logic sosc_en;
    osc_sel_t osc_sel;
  } clk_cfg_t;

  localparam clk_cfg_t RST_CFG = '{2'h0, 1'b1, POSC_OFF, 1'b0, 1'b0, SRC_FRC};

endpackage

// File: verilog/boot_clock_config_decode.sv
// Boot clock configuration decoder with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - The divisor field at bits 13:12 makes the peripheral bus clock the system clock over 1, 2, 4 or 8.
// - Clock-out bit 10 set keeps the clock output off; clear drives it on the oscillator output pin.
// - The clock output is active only with primary oscillator mode 11 or 00.
// - Mode field bits 9:8 selects disabled, high-speed crystal, crystal or external clock for 11, 10, 01, 00.
// - Bit 7 set enables two-speed start-up and clear disables it.
// - Bit 5 set turns the secondary oscillator on and clear keeps it off.
// - Selection 111, 110, 101, 100 give fast RC divided, fast RC over 16, low-power RC, secondary oscillator.
// - Selection 011, 010, 001, 000 give primary with PLL, primary direct, fast RC divided with PLL, fast RC.
module boot_clock_config_decode
  import boot_clk_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire cfg_words_t cfg_words_i,
  output clk_cfg_t clk_cfg_o,
  output logic cfg_valid_o,
  output logic [3:0] posc_mode_onehot_o,
  output logic [7:0] osc_src_onehot_o,
  output logic pll_enable_o,
  output logic two_speed_startup_enable_o,
  output logic secondary_osc_enable_o,
  output logic periph_clk_en_o,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe_n_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // The register decode compares address bits 15:0, so narrower buses cannot be served.
  if (ADDR_W < 16 || ADDR_W > 32) begin : gen_addr_w_check
    $error("ADDR_W must lie between 16 and 32");
  end

  typedef enum logic [3:0] {
    ST_SYNC0 = 4'b0001,
    ST_SYNC1 = 4'b0010,
    ST_SYNC2 = 4'b0100,
    ST_HOLD = 4'b1000
  } latch_st_t;

  function automatic clk_cfg_t unpack_word(input logic [31:0] w);
    clk_cfg_t c;
    c.periph_div = w[POS_PERIPH_DIV +: 2];
    c.clkout_dis = w[POS_CLKOUT_DIS];
    c.posc_mode = posc_mode_t'(w[POS_POSC_MODE +: 2]);
    c.two_speed = w[POS_TWO_SPEED];
    c.sosc_en = w[POS_SOSC_EN];
    c.osc_sel = osc_sel_t'(w[POS_OSC_SEL +: 3]);
    return c;
  endfunction

  function automatic logic [2:0] div_mask(input logic [1:0] code);
    logic [2:0] m;
    m = 3'h0;
    unique case (code)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
    endcase
    return m;
  endfunction

  cfg_words_t sync1_ff;
  cfg_words_t sync2_ff;
  cfg_words_t words_ff;
  clk_cfg_t cfg_ff;
  latch_st_t st_ff;
  logic valid_ff;
  logic rsvd_err_ff;
  logic conflict_ff;
  logic [2:0] div_cnt_ff;
  logic pclk_en_ff;
  logic osc_out_ff;
  logic osc_oe_n_ff;
  logic suppress_ff;
  logic [3:0] posc_oh_ff;
  logic [7:0] src_oh_ff;
  logic pll_ff;
  logic clkout_active;

  // The words come from nonvolatile storage outside this clock domain.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= cfg_words_i;
      sync2_ff <= sync1_ff;
    end
  end

  // Capture waits for the synchroniser to fill, then freezes until the next reset.
  // The second stage holds the words only after the second edge, hence three states.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ST_SYNC0;
      valid_ff <= 1'b0;
      words_ff <= '0;
      cfg_ff <= RST_CFG;
      rsvd_err_ff <= 1'b0;
      conflict_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_SYNC0: st_ff <= ST_SYNC1;
        ST_SYNC1: st_ff <= ST_SYNC2;
        ST_SYNC2: begin
          st_ff <= ST_HOLD;
          valid_ff <= 1'b1;
          words_ff <= sync2_ff;
          cfg_ff <= unpack_word(sync2_ff.word_one);
          // Wrong reserved bits are flagged, not corrected.
          rsvd_err_ff <= ~(sync2_ff.word_one[POS_RSVD_B11] & sync2_ff.word_one[POS_RSVD_B6]
                           & (&sync2_ff.word_one[POS_RSVD_B3 +: 2]));
          conflict_ff <= (sync2_ff.word_one[POS_OSC_SEL +: 3] == SRC_POSC)
                         && (sync2_ff.word_one[POS_POSC_MODE +: 2] == POSC_OFF);
        end
        ST_HOLD: st_ff <= ST_HOLD;
      endcase
    end
  end

  // Decoded selects are held in flops so every output is registered.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      posc_oh_ff <= 4'h0;
      src_oh_ff <= 8'h00;
      pll_ff <= 1'b0;
    end else begin
      posc_oh_ff <= valid_ff ? (4'h1 << cfg_ff.posc_mode) : 4'h0;
      src_oh_ff <= valid_ff ? (8'h01 << cfg_ff.osc_sel) : 8'h00;
      pll_ff <= valid_ff && (cfg_ff.osc_sel == SRC_POSC_PLL
                             || cfg_ff.osc_sel == SRC_FAST_RC_DIVIDED_PLL);
    end
  end

  // The peripheral clock is delivered as a one-in-N enable on the system clock.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_ff <= 3'h0;
      pclk_en_ff <= 1'b0;
    end else begin
      div_cnt_ff <= valid_ff ? div_cnt_ff + 3'h1 : 3'h0;
      pclk_en_ff <= valid_ff
                    && ((div_cnt_ff & div_mask(cfg_ff.periph_div))
                        == div_mask(cfg_ff.periph_div));
    end
  end

  assign clkout_active = valid_ff && !cfg_ff.clkout_dis && !suppress_ff
                         && (cfg_ff.posc_mode == POSC_OFF
                             || cfg_ff.posc_mode == POSC_EXT);

  // The pin carries half the system clock, the fastest a flop can drive.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_out_ff <= 1'b0;
      osc_oe_n_ff <= 1'b1;
    end else begin
      osc_out_ff <= clkout_active ? ~osc_out_ff : 1'b0;
      osc_oe_n_ff <= ~clkout_active;
    end
  end

  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;
  logic do_write;
  logic [31:0] status_word;

  assign aw_hs = s_axi_awvalid_i && awready_ff;
  assign w_hs = s_axi_wvalid_i && wready_ff;
  assign b_hs = bvalid_ff && s_axi_bready_i;
  assign ar_hs = s_axi_arvalid_i && arready_ff;
  assign r_hs = rvalid_ff && s_axi_rready_i;
  assign do_write = (aw_got_ff || aw_hs) && (w_got_ff || w_hs) && !bvalid_ff;
  assign nxt_aw_got = (aw_got_ff || aw_hs) && !do_write;
  assign nxt_w_got = (w_got_ff || w_hs) && !do_write;
  assign nxt_bvalid = do_write || (bvalid_ff && !b_hs);
  assign status_word = {28'h0, ~osc_oe_n_ff, conflict_ff, rsvd_err_ff, valid_ff};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= RST_WORD;
      wstrb0_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata_i;
        wstrb0_ff <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        unique case (aw_hs ? s_axi_awaddr_i[15:0] : awaddr_ff[15:0])
          ADDR_CLK_CONTROL: bresp_ff <= RESP_OKAY;
          ADDR_CFG_WORD_THREE, ADDR_CFG_WORD_TWO, ADDR_CFG_WORD_ONE,
          ADDR_CFG_WORD_ZERO, ADDR_CLK_STATUS: bresp_ff <= RESP_SLVERR;
          default: bresp_ff <= RESP_DECERR;
        endcase
      end
    end
  end

  // Software may only add a gate on the clock output, never force it on.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      suppress_ff <= RST_SUPPRESS;
    end else if (do_write
                 && (aw_hs ? s_axi_awaddr_i[15:0] : awaddr_ff[15:0]) == ADDR_CLK_CONTROL
                 && (w_hs ? s_axi_wstrb_i[0] : wstrb0_ff)) begin
      suppress_ff <= w_hs ? s_axi_wdata_i[POS_CTL_SUPPRESS] : wdata_ff[POS_CTL_SUPPRESS];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= RST_WORD;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= !(ar_hs || (rvalid_ff && !r_hs));
      if (ar_hs) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        unique case (s_axi_araddr_i[15:0])
          ADDR_CFG_WORD_THREE: rdata_ff <= words_ff.word_three;
          ADDR_CFG_WORD_TWO: rdata_ff <= words_ff.word_two;
          ADDR_CFG_WORD_ONE: rdata_ff <= words_ff.word_one;
          ADDR_CFG_WORD_ZERO: rdata_ff <= words_ff.word_zero;
          ADDR_CLK_STATUS: rdata_ff <= status_word;
          ADDR_CLK_CONTROL: rdata_ff <= {31'h0, suppress_ff};
          default: begin
            rdata_ff <= RST_WORD;
            rresp_ff <= RESP_DECERR;
          end
        endcase
      end else if (r_hs) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign clk_cfg_o = cfg_ff;
  assign cfg_valid_o = valid_ff;
  assign posc_mode_onehot_o = posc_oh_ff;
  assign osc_src_onehot_o = src_oh_ff;
  assign pll_enable_o = pll_ff;
  assign two_speed_startup_enable_o = cfg_ff.two_speed;
  assign secondary_osc_enable_o = cfg_ff.sosc_en;
  assign periph_clk_en_o = pclk_en_ff;
  assign osc_output_pin_o = osc_out_ff;
  assign osc_output_pin_oe_n_o = osc_oe_n_ff;
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_DIV8_PERIOD: assert property (valid_ff && pclk_en_ff && cfg_ff.periph_div == 2'h3
    |=> !pclk_en_ff [*7] ##1 pclk_en_ff) else $error("divide by 8 period wrong");
  AST_DIV1_EVERY: assert property ($past(valid_ff) && cfg_ff.periph_div == 2'h0
    |-> pclk_en_ff) else $error("divide by 1 enable missing");
  AST_CLKOUT_OFF: assert property (valid_ff && cfg_ff.clkout_dis
    |=> osc_oe_n_ff && !osc_out_ff) else $error("clock output not disabled");
  AST_CLKOUT_ON: assert property (clkout_active
    |=> !osc_oe_n_ff ##0 (osc_out_ff != $past(osc_out_ff))) else $error("clock output idle");
  AST_CLKOUT_MODE: assert property ((cfg_ff.posc_mode == POSC_XT || cfg_ff.posc_mode == POSC_HS)
    |=> osc_oe_n_ff) else $error("clock output active in crystal mode");
  AST_POSC_DECODE: assert property ($past(valid_ff)
    |-> posc_oh_ff == (4'h1 << cfg_ff.posc_mode)) else $error("primary mode decode wrong");
  AST_TWO_SPEED: assert property (st_ff == ST_SYNC2
    |=> two_speed_startup_enable_o == $past(sync2_ff.word_one[POS_TWO_SPEED]))
    else $error("two-speed bit not taken");
  AST_SOSC: assert property (st_ff == ST_SYNC2
    |=> secondary_osc_enable_o == $past(sync2_ff.word_one[POS_SOSC_EN]))
    else $error("secondary oscillator bit not taken");
  AST_SRC_HIGH: assert property ($past(valid_ff) && cfg_ff.osc_sel[2]
    |-> src_oh_ff[7:4] == (4'h1 << cfg_ff.osc_sel[1:0]) && !pll_ff)
    else $error("upper source decode wrong");
  AST_SRC_LOW: assert property ($past(valid_ff) && !cfg_ff.osc_sel[2]
    |-> src_oh_ff[3:0] == (4'h1 << cfg_ff.osc_sel[1:0]) && pll_ff == cfg_ff.osc_sel[0])
    else $error("lower source decode wrong");
  AST_CONFLICT: assert property (st_ff == ST_SYNC2 && sync2_ff.word_one[2:0] == 3'h2
    && sync2_ff.word_one[9:8] == 2'h3 |=> conflict_ff) else $error("conflict not flagged");
  AST_HOLD: assert property (valid_ff |=> valid_ff && $stable(cfg_ff) && $stable(words_ff))
    else $error("latched configuration changed");
  AST_B_HOLD: assert property (bvalid_ff && !s_axi_bready_i |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped");

  COV_DIV8: cover property (valid_ff && cfg_ff.periph_div == 2'h3 && pclk_en_ff);
  COV_CLKOUT: cover property (!osc_oe_n_ff ##1 !osc_oe_n_ff);
  COV_READ: cover property (ar_hs ##1 r_hs);
  COV_WRITE: cover property (do_write ##1 b_hs);

endmodule // boot_clock_config_decode
`default_nettype wire

// File: sim/tb_boot_clock_config_decode.sv
// Self-checking testbench for the boot clock configuration decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_boot_clock_config_decode;
  import boot_clk_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  cfg_words_t cfg_words_i = '0;
  clk_cfg_t clk_cfg_o;
  logic cfg_valid_o, pll_enable_o, two_speed_startup_enable_o, secondary_osc_enable_o;
  logic periph_clk_en_o, osc_output_pin_o, osc_output_pin_oe_n_o;
  logic [3:0] posc_mode_onehot_o;
  logic [7:0] osc_src_onehot_o;
  logic [15:0] s_axi_awaddr_i = '0;
  logic [15:0] s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 37;
  logic [31:0] exp_words[$];

  boot_clock_config_decode uut (
    .mclk_i, .nrst_i, .cfg_words_i, .clk_cfg_o, .cfg_valid_o, .posc_mode_onehot_o,
    .osc_src_onehot_o, .pll_enable_o, .two_speed_startup_enable_o, .secondary_osc_enable_o,
    .periph_clk_en_o, .osc_output_pin_o, .osc_output_pin_oe_n_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i
  );

  always #2.5 mclk_i = ~mclk_i;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The whole run needs about 1000 cycles, so this ceiling only trips on a hang.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("unexpected timeout: expected completion seen hang");
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Write and read masters hold each channel until its own ready is sampled high.
  task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awvalid_i && s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", er, s_axi_bresp_o);
  endtask

  task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arvalid_i && s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rdata", ed, s_axi_rdata_o);
    chk("rresp", er, s_axi_rresp_o);
  endtask

  task automatic do_reset(input cfg_words_t w);
    nrst_i <= 1'b0;
    cfg_words_i <= w;
    repeat (10) @(posedge mclk_i);
    chk("valid_rst", 32'h0, cfg_valid_o);
    chk("oe_n_rst", 32'h1, osc_output_pin_oe_n_o);
    chk("pin_rst", 32'h0, osc_output_pin_o);
    chk("pclk_rst", 32'h0, periph_clk_en_o);
    chk("cfg_rst", RST_CFG, clk_cfg_o);
    chk("awready_rst", 32'h0, s_axi_awready_o);
    nrst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
  endtask

  initial begin
    cfg_words_t w;
    logic [31:0] w1;
    logic p;
    int mode, div, sel, n;
    bit act, rsv, cnf;
    for (int i = 0; i < 8; i++) begin
      sel = i;
      mode = (i == 2) ? 3 : i % 4;
      div = i / 2;
      w1 = $random(seed);
      w1[2:0] = sel[2:0];
      w1[9:8] = mode[1:0];
      w1[13:12] = div[1:0];
      w1[10] = (i >= 4);
      w = {$random(seed), $random(seed), w1, $random(seed)};
      exp_words = {w.word_three, w.word_two, w.word_one, w.word_zero};
      act = !w1[10] && (mode == 0 || mode == 3);
      rsv = !(w1[11] && w1[6] && w1[4] && w1[3]);
      cnf = (sel == 2) && (mode == 3);
      do_reset(w);
      chk("valid", 32'h1, cfg_valid_o);
      chk("cfg", {w1[13:12], w1[10], w1[9:8], w1[7], w1[5], w1[2:0]}, clk_cfg_o);
      chk("mode_oh", 32'h1 << mode, posc_mode_onehot_o);
      chk("src_oh", 32'h1 << sel, osc_src_onehot_o);
      chk("pll", (sel == 3 || sel == 1), pll_enable_o);
      chk("two_speed", w1[7], two_speed_startup_enable_o);
      chk("sosc", w1[5], secondary_osc_enable_o);
      chk("oe_n", !act, osc_output_pin_oe_n_o);
      p = osc_output_pin_o;
      @(posedge mclk_i);
      chk("pin", 32'(act && !p), osc_output_pin_o);
      n = 0;
      repeat (64) begin
        @(posedge mclk_i);
        n += periph_clk_en_o;
      end
      chk("pclk_count", 64 >> div, n);
      axi_rd(ADDR_CLK_CONTROL, {31'h0, RST_SUPPRESS}, RESP_OKAY);
      for (int k = 0; k < 4; k++)
        axi_rd(ADDR_CFG_WORD_THREE + 16'(4 * k), exp_words[k], RESP_OKAY);
      axi_rd(ADDR_CLK_STATUS, {28'h0, act, cnf, rsv, 1'b1}, RESP_OKAY);
      axi_wr(ADDR_CFG_WORD_ONE, ~w1, RESP_SLVERR);
      axi_wr(ADDR_CLK_STATUS, 32'h0, RESP_SLVERR);
      axi_wr(16'h1000, 32'h0, RESP_DECERR);
      axi_rd(16'h1000, 32'h0, RESP_DECERR);
      axi_rd(ADDR_CFG_WORD_ONE, w1, RESP_OKAY);
      if (act) begin
        axi_wr(ADDR_CLK_CONTROL, 32'h1, RESP_OKAY);
        repeat (3) @(posedge mclk_i);
        chk("oe_n_sup", 32'h1, osc_output_pin_oe_n_o);
        chk("pin_sup", 32'h0, osc_output_pin_o);
        axi_rd(ADDR_CLK_CONTROL, 32'h1, RESP_OKAY);
        axi_wr(ADDR_CLK_CONTROL, 32'h0, RESP_OKAY);
        repeat (3) @(posedge mclk_i);
        chk("oe_n_back", 32'h0, osc_output_pin_oe_n_o);
      end
      // Changing the words after capture must leave every decoded field alone.
      cfg_words_i <= ~w;
      repeat (6) @(posedge mclk_i);
      chk("cfg_held", {w1[13:12], w1[10], w1[9:8], w1[7], w1[5], w1[2:0]}, clk_cfg_o);
      axi_rd(ADDR_CFG_WORD_ONE, w1, RESP_OKAY);
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule // tb_boot_clock_config_decode
`default_nettype wire
